// ==== pkg/vpf_pkg.sv ====
// Shared constants for the video pixel format and raster timing block.
// Assumes a single pixel clock domain; all users import vpf_pkg::*.
package vpf_pkg;

  // Pixel depth select codes
  localparam logic [1:0] BPP_1 = 2'h0;
  localparam logic [1:0] BPP_2 = 2'h1;
  localparam logic [1:0] BPP_4 = 2'h2;
  localparam logic [1:0] BPP_8 = 2'h3;

  // FIFO word and cursor geometry
  localparam int WORD_BITS    = 32;
  localparam int CURSOR_WIDTH = 32;
  localparam int CURSOR_BPP   = 2;

  // Physical colour word layout: flag, blue, green, red
  localparam int COLOUR_BITS = 13;
  localparam int SUP_BIT     = 12;
  localparam int BLUE_LSB    = 8;
  localparam int GREEN_LSB   = 4;
  localparam int RED_LSB     = 0;

  // Bits overwritten by logical pixel bits at eight bits per pixel
  localparam int L7_POS = 11;
  localparam int L6_POS = 7;
  localparam int L5_POS = 6;
  localparam int L4_POS = 3;

  // Palette slots: 16 video entries, then border, then cursor 1..3
  localparam int          PAL_SLOTS  = 20;
  localparam logic [4:0]  PAL_BORDER = 5'h10;
  localparam logic [4:0]  PAL_CURSOR = 5'h10;

  // Reset values
  localparam logic [12:0] COLOUR_RST = 13'h0000;

  // Cursor pixel code meaning transparent
  localparam logic [1:0]  CUR_CLEAR  = 2'h0;

endpackage

// ==== rtl/vpf_pixel_unpack.sv ====
// Unpacks 32-bit FIFO words into pixels, least significant end first.
// Assumes the word source holds o_pop's word stable until popped.
`timescale 1ns/10ps
module vpf_pixel_unpack
  import vpf_pkg::*;
(
  // Clock and reset
  input  wire logic        i_clk,
  input  wire logic        i_sys_rst,
  // Control
  input  wire logic        i_advance,
  input  wire logic [1:0]  i_bpp,
  // Word source
  input  wire logic [31:0] i_word,
  input  wire logic        i_word_valid,
  output logic             o_pop,
  // Current pixel, low bits valid
  output logic [7:0]       o_pixel
);

  logic [31:0] word;    // Word being shown
  logic [4:0]  bit_idx; // Position of current pixel
  logic        loaded;  // Word register holds data
  logic [5:0]  step;    // Bits per pixel
  logic [5:0]  next_idx;

  // Width of one pixel in bits
  assign step     = 6'(1) << i_bpp;
  assign next_idx = {1'b0, bit_idx} + step;
  // Refill when empty or when the last pixel of the word is consumed
  assign o_pop    = i_word_valid && (!loaded || (i_advance && next_idx[5]));
  // First pixel sits in bits 0 upward
  assign o_pixel  = 8'(word >> bit_idx);

  // Word register and pixel pointer
  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      word    <= 32'h0000_0000;
      bit_idx <= 5'h0;
      loaded  <= 1'b0;
    end else if (o_pop) begin
      word    <= i_word;
      bit_idx <= 5'h0;
      loaded  <= 1'b1;
    end else if (i_advance && loaded) begin
      // Underrun leaves the word empty; pixels then repeat stale data
      bit_idx <= next_idx[4:0];
      if (next_idx[5]) begin
        loaded <= 1'b0;
      end
    end
  end

endmodule

// ==== rtl/vpf_palette.sv ====
// Colour palette: 16 video entries, border colour and three cursor colours.
// Assumes writes come from the pixel clock domain.
`timescale 1ns/10ps
module vpf_palette
  import vpf_pkg::*;
(
  // Clock and reset
  input  wire logic        i_clk,
  input  wire logic        i_sys_rst,
  // Write port
  input  wire logic        i_wr,
  input  wire logic [4:0]  i_addr,
  input  wire logic [12:0] i_data,
  // Lookups
  input  wire logic [3:0]  i_video_index,
  input  wire logic [1:0]  i_cursor_code,
  output logic [12:0]      o_video_colour,
  output logic [12:0]      o_cursor_colour,
  output logic [12:0]      o_border_colour
);

  logic [12:0] entry [PAL_SLOTS]; // Palette storage

  // Palette writes; reset gives black everywhere
  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      for (int i = 0; i < PAL_SLOTS; i++) begin
        entry[i] <= COLOUR_RST;
      end
    end else if (i_wr && (int'(i_addr) < PAL_SLOTS)) begin
      entry[i_addr] <= i_data;
    end
  end

  // Same physical layout for video, border and cursor
  assign o_video_colour  = entry[i_video_index];
  assign o_border_colour = entry[PAL_BORDER];
  assign o_cursor_colour = entry[PAL_CURSOR + 5'(i_cursor_code)];

endmodule

// ==== rtl/vpf_timing.sv ====
// Raster timing, pixel formatting, cursor overlay and DMA request gating.
// Assumes i_clk is the pixel clock and settings change only in flyback.
//
// Behaviour
// - Vertical sync width value is rasters minus one
// - Border generated only inside its window, no separate enable bit
// - Cursor never shown outside border region
// - First pixel from least significant word bits
// - Pixel value indexes palette entries per depth
// - Eight bit mode: high nibble drives DACs
// - L7,L6,L5,L4 replace bits 11,7,6,3
// - Colour word: flag, blue, green, red
// - Cursor 32 pixels wide, two bits each
// - Cursor code zero transparent, else colours 1-3
// - Cursor and border share video colour layout
// - Vertical display end below start: border only, no requests
// - Border start above end: hide border, cursor
// - Cursor end below start: hide, stop requests
// - Zero horizontal front porch works correctly
// - Flyback flag from raster after display to display
`timescale 1ns/10ps
module vpf_timing
  import vpf_pkg::*;
#(
  parameter int H_W = 11, // Horizontal counter width
  parameter int V_W = 10  // Vertical counter width
)(
  // Clock and reset
  input  wire logic           i_clk,
  input  wire logic           i_sys_rst,
  // Mode
  input  wire logic [1:0]     i_bpp,
  // Horizontal settings, in pixels from line start
  input  wire logic [H_W-1:0] i_h_cycle,
  input  wire logic [H_W-1:0] i_h_sync_width,
  input  wire logic [H_W-1:0] i_h_border_start,
  input  wire logic [H_W-1:0] i_h_display_start,
  input  wire logic [H_W-1:0] i_h_display_end,
  input  wire logic [H_W-1:0] i_h_border_end,
  input  wire logic [H_W-1:0] i_h_cursor_start,
  // Vertical settings, in rasters
  input  wire logic [V_W-1:0] i_vert_cycle,
  input  wire logic [V_W-1:0] i_vert_sync_width_reg,
  input  wire logic [V_W-1:0] i_vert_border_start_reg,
  input  wire logic [V_W-1:0] i_vert_display_start_reg,
  input  wire logic [V_W-1:0] i_vert_display_end_reg,
  input  wire logic [V_W-1:0] i_vert_border_end_reg,
  input  wire logic [V_W-1:0] i_vert_cursor_start_reg,
  input  wire logic [V_W-1:0] i_vert_cursor_end_reg,
  // Palette write port
  input  wire logic           i_pal_wr,
  input  wire logic [4:0]     i_pal_addr,
  input  wire logic [12:0]    i_pal_data,
  // Video data source
  input  wire logic [31:0]    i_video_word,
  input  wire logic           i_video_valid,
  input  wire logic           i_video_fifo_low,
  output logic                o_video_pop,
  // Cursor data source
  input  wire logic [31:0]    i_cursor_word,
  input  wire logic           i_cursor_valid,
  output logic                o_cursor_pop,
  // DMA requests
  output logic                o_video_dma_request,
  output logic                o_cursor_dma_request,
  // Sync and status
  output logic                o_line_sync_out_n,
  output logic                o_frame_sync_n,
  output logic                o_flyback_flag,
  // DAC side
  output logic [11:0]         o_colour,
  output logic                o_overlay_select_flag
);

  // Raster counters
  logic [H_W-1:0] hcnt;
  logic [V_W-1:0] vcnt;
  logic           line_end;   // Last pixel of the raster
  logic           line_start; // First pixel of the raster

  // Window decodes
  logic h_sync, h_disp, h_bord, h_cur;
  logic v_sync, v_disp, v_bord, v_cur;
  logic [H_W:0] h_cur_end;    // One past the last cursor pixel
  logic         cur_par;      // Cursor raster pair phase

  // Pixel path
  logic [7:0]  vid_pixel;     // Logical video pixel
  logic [7:0]  cur_pixel;     // Cursor pixel, low two bits used
  logic [1:0]  cur_code;      // Cursor code after gating
  logic [3:0]  vid_index;     // Palette address
  logic [12:0] pal_video, pal_cursor, pal_border;
  logic [12:0] vid_colour;    // Video colour after depth handling
  logic [12:0] next_colour;   // Colour before the output register

  assign line_end   = (hcnt == i_h_cycle);
  assign line_start = (hcnt == '0);

  // Horizontal counter; wrapping straight from display end is fine
  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      hcnt <= '0;
    end else if (line_end) begin
      hcnt <= '0;
    end else begin
      hcnt <= hcnt + 1'b1;
    end
  end

  // Vertical counter, steps at the end of each raster
  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      vcnt <= '0;
    end else if (line_end) begin
      vcnt <= (vcnt == i_vert_cycle) ? '0 : vcnt + 1'b1;
    end
  end

  // Horizontal windows; sync starts the raster
  assign h_sync    = (hcnt < i_h_sync_width);
  assign h_disp    = (hcnt >= i_h_display_start) && (hcnt < i_h_display_end);
  assign h_bord    = (hcnt >= i_h_border_start) && (hcnt < i_h_border_end);
  assign h_cur_end = {1'b0, i_h_cursor_start} + (H_W+1)'(CURSOR_WIDTH);
  assign h_cur     = ({1'b0, hcnt} >= {1'b0, i_h_cursor_start}) && ({1'b0, hcnt} < h_cur_end);

  // Vertical windows; an inverted pair yields an empty window
  assign v_sync = (vcnt <= i_vert_sync_width_reg);
  assign v_disp = (vcnt >= i_vert_display_start_reg) && (vcnt < i_vert_display_end_reg);
  assign v_bord = (vcnt >= i_vert_border_start_reg) && (vcnt < i_vert_border_end_reg);
  assign v_cur  = (vcnt >= i_vert_cursor_start_reg) && (vcnt < i_vert_cursor_end_reg);

  // Cursor data arrives every other cursor raster; phase restarts each cursor run
  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      cur_par <= 1'b0;
    end else if (line_end) begin
      cur_par <= v_cur ? !cur_par : 1'b0;
    end
  end

  // Sync outputs, active low, registered
  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      o_line_sync_out_n <= 1'b1;
      o_frame_sync_n    <= 1'b1;
    end else begin
      o_line_sync_out_n <= !h_sync;
      o_frame_sync_n    <= !v_sync;
    end
  end

  // Flyback flag decided once per raster, at its start
  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      o_flyback_flag <= 1'b1;
    end else if (line_start) begin
      o_flyback_flag <= !v_disp;
    end
  end

  // DMA requests; video outside line sync, cursor inside it
  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      o_video_dma_request  <= 1'b0;
      o_cursor_dma_request <= 1'b0;
    end else begin
      // No video requests when the vertical display window is empty
      o_video_dma_request  <= v_disp && !h_sync && i_video_fifo_low;
      // Cursor fetches ignore the border window but stop with the cursor
      o_cursor_dma_request <= v_disp && v_cur && h_sync && !cur_par;
    end
  end

  // Video pixel unpacker
  vpf_pixel_unpack u_video_unpack (
    .i_clk        (i_clk),
    .i_sys_rst    (i_sys_rst),
    .i_advance    (h_disp && v_disp),
    .i_bpp        (i_bpp),
    .i_word       (i_video_word),
    .i_word_valid (i_video_valid),
    .o_pop        (o_video_pop),
    .o_pixel      (vid_pixel)
  );

  // Cursor unpacker: fixed two bits per pixel, bits 1:0 first
  vpf_pixel_unpack u_cursor_unpack (
    .i_clk        (i_clk),
    .i_sys_rst    (i_sys_rst),
    .i_advance    (h_cur && v_cur),
    .i_bpp        (BPP_2),
    .i_word       (i_cursor_word),
    .i_word_valid (i_cursor_valid),
    .o_pop        (o_cursor_pop),
    .o_pixel      (cur_pixel)
  );

  // Palette index by depth 8 bpp uses the low nibble
  always_comb begin
    case (i_bpp)
      BPP_1:   vid_index = {3'h0, vid_pixel[0]};
      BPP_2:   vid_index = {2'h0, vid_pixel[1:0]};
      BPP_4:   vid_index = vid_pixel[3:0];
      BPP_8:   vid_index = vid_pixel[3:0];
      default: vid_index = 4'h0;
    endcase
  end

  // Cursor visible only inside its window and the border region
  assign cur_code = (h_cur && v_cur && h_bord && v_bord) ? cur_pixel[1:0] : CUR_CLEAR;

  // Palette store
  vpf_palette u_palette (
    .i_clk           (i_clk),
    .i_sys_rst       (i_sys_rst),
    .i_wr            (i_pal_wr),
    .i_addr          (i_pal_addr),
    .i_data          (i_pal_data),
    .i_video_index   (vid_index),
    .i_cursor_code   (cur_code),
    .o_video_colour  (pal_video),
    .o_cursor_colour (pal_cursor),
    .o_border_colour (pal_border)
  );

  // Eight bit mode: upper logical bits replace selected palette bits
  always_comb begin
    vid_colour = pal_video;
    if (i_bpp == BPP_8) begin
      vid_colour[L7_POS] = vid_pixel[7];
      vid_colour[L6_POS] = vid_pixel[6];
      vid_colour[L5_POS] = vid_pixel[5];
      vid_colour[L4_POS] = vid_pixel[4];
    end
  end

  // Priority: cursor, then display, then border; black outside display and border
  always_comb begin
    if (cur_code != CUR_CLEAR) begin
      next_colour = pal_cursor;
    end else if (h_disp && v_disp) begin
      next_colour = vid_colour;
    end else if (h_bord && v_bord) begin
      next_colour = pal_border;
    end else begin
      next_colour = COLOUR_RST;
    end
  end

  // One output register keeps flag and DAC bits on the same pixel
  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      o_colour              <= COLOUR_RST[11:0];
      o_overlay_select_flag <= COLOUR_RST[SUP_BIT];
    end else begin
      o_colour              <= next_colour[11:0];
      o_overlay_select_flag <= next_colour[SUP_BIT];
    end
  end

  // Checks
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_sys_rst);

  sequence s_second_raster_begins;
    line_start && (vcnt == V_W'(1)) && (i_vert_sync_width_reg == '0);
  endsequence

  AST_VSYNC_ONE_RASTER: assert property (s_second_raster_begins |=> o_frame_sync_n)
    else $error("frame sync longer than one raster at width zero");

  AST_BORDER_SHOWN: assert property ((h_bord && v_bord && !(h_disp && v_disp) && cur_code == CUR_CLEAR)
    |=> o_colour == $past(pal_border[11:0]))
    else $error("border colour not shown in border region");

  // Outside the border only display pixels may appear; a cursor pixel never does
  AST_CURSOR_CLIPPED: assert property (!(h_bord && v_bord) |-> (cur_code == CUR_CLEAR) ##1
    ((o_colour == ($past(h_disp && v_disp) ? $past(vid_colour[11:0]) : 12'h000)) &&
    (o_overlay_select_flag == ($past(h_disp && v_disp) && $past(vid_colour[SUP_BIT])))))
    else $error("cursor or border shown outside border region");

  AST_INDEX_1BPP: assert property ((i_bpp == BPP_1) |-> (vid_index[3:1] == 3'h0))
    else $error("one bit mode addressed beyond entry one");

  AST_8BPP_BITS: assert property ((i_bpp == BPP_8) && h_disp && v_disp && (cur_code == CUR_CLEAR)
    |=> (o_colour[L7_POS] == $past(vid_pixel[7])) && (o_colour[L4_POS] == $past(vid_pixel[4])))
    else $error("logical bits not placed in eight bit colour");

  AST_NO_VIDEO_REQ: assert property ((i_vert_display_end_reg < i_vert_display_start_reg)
    |=> !o_video_dma_request)
    else $error("video request with display disabled");

  // Display still shows with the border off; only border and cursor vanish
  AST_BORDER_OFF: assert property ((i_vert_border_start_reg > i_vert_border_end_reg)
    |-> (cur_code == CUR_CLEAR) ##1 (o_colour == ($past(h_disp && v_disp) ? $past(vid_colour[11:0]) : 12'h000)))
    else $error("border or cursor shown while suppressed");

  AST_CURSOR_REQ_OFF: assert property ((i_vert_cursor_end_reg < i_vert_cursor_start_reg)
    |=> !o_cursor_dma_request)
    else $error("cursor request with cursor disabled");

  AST_FLYBACK: assert property (line_start && v_disp |=> !o_flyback_flag [*2])
    else $error("flyback high on a display raster");

  AST_SUP_ALIGN: assert property ((next_colour[SUP_BIT] && cur_code != CUR_CLEAR)
    |=> o_overlay_select_flag && (o_colour == $past(pal_cursor[11:0])))
    else $error("overlay flag out of step with colour");

endmodule

// ==== bench/vpf_far_side.sv ====
// Far-side model: monitor sync capture plus video and cursor word source.
// Assumes registered sync outputs and a combinational video pop strobe.
`timescale 1ns/10ps
module vpf_far_side (
  // Clock and reset
  input  wire logic        i_clk,
  input  wire logic        i_sys_rst,
  // Test controls
  input  wire logic [31:0] i_vid_pat,
  input  wire logic [31:0] i_cur_pat,
  input  wire logic        i_slow,
  // From the design
  input  wire logic        i_video_pop,
  input  wire logic        i_line_n,
  input  wire logic        i_frame_n,
  input  wire logic        i_vreq,
  input  wire logic        i_creq,
  // To the design
  output logic [31:0]      o_vid_word,
  output logic             o_vid_valid,
  output logic [31:0]      o_cur_word,
  // Monitor measurements
  output int               o_frame,
  output int               o_raster,
  output int               o_frame_low,
  output int               o_vreq_cnt,
  output int               o_creq_cnt
);
  logic line_q;  // Previous line sync level
  logic frame_q; // Previous frame sync level
  int   low_run; // Frame sync low cycles so far

  // Words stay primed so data leads display start
  // Slow mode drops valid for a cycle after each pop
  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      o_vid_valid <= 1'b1;
    end else begin
      o_vid_valid <= !(i_slow && i_video_pop);
    end
  end

  // A gap shows inverted data, so a stale word cannot pass for good
  assign o_vid_word = o_vid_valid ? i_vid_pat : ~i_vid_pat;
  assign o_cur_word = i_cur_pat;

  // Monitor: frame and raster count, frame sync width, request counts
  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      line_q      <= 1'b1;
      frame_q     <= 1'b1;
      o_frame     <= 0;
      o_raster    <= 0;
      low_run     <= 0;
      o_frame_low <= 0;
      o_vreq_cnt  <= 0;
      o_creq_cnt  <= 0;
    end else begin
      line_q  <= i_line_n;
      frame_q <= i_frame_n;
      // Frame start restarts the raster count
      if (frame_q && !i_frame_n) begin
        o_frame  <= o_frame + 1;
        o_raster <= 0;
      end else if (line_q && !i_line_n) begin
        o_raster <= o_raster + 1;
      end
      low_run <= i_frame_n ? 0 : low_run + 1;
      if (!frame_q && i_frame_n) begin
        o_frame_low <= low_run;
      end
      o_vreq_cnt <= o_vreq_cnt + int'(i_vreq);
      o_creq_cnt <= o_creq_cnt + int'(i_creq);
    end
  end
endmodule

// ==== bench/video_pixel_format_timing_tb_top.sv ====
// Self-checking bench for the raster timing and pixel format block.
// Assumes vpf_pkg and the far-side model are compiled first.
`timescale 1ns/10ps
module video_pixel_format_timing_tb_top;
  import vpf_pkg::*;
  typedef struct packed {logic [1:0] b; logic [31:0] w; logic [9:0] vsw; logic s; logic [10:0] fl;} vpf_row_t;

  logic        clk  = 1'b0;         // Pixel clock
  logic        rst  = 1'b1;         // Reset
  logic [1:0]  bpp  = BPP_4;        // Depth
  logic [10:0] hc[7] = '{default: '0}; // Horizontal settings
  logic [9:0]  vc[8] = '{default: '0}; // Vertical settings
  logic        wr   = 1'b0;         // Palette write strobe
  logic [4:0]  pa   = 5'h00;        // Palette address
  logic [12:0] pd   = 13'h0000;     // Palette data
  logic [31:0] vpat = 32'h0000_0000; // Video word pattern
  logic [31:0] cpat = 32'hFFFF_FFE4; // Cursor codes 0,1,2,3 then 3s
  logic        slow = 1'b0;         // Slow word source
  logic [31:0] vword, cword;
  logic        vvalid, vpop, line_n, frame_n, fly, vreq, creq, overlay_select_flag;
  logic [11:0] col;
  int          far_frame, far_raster, far_frame_low, far_vreq, far_creq;
  int          n_mismatch = 0;
  int          check_count = 0;
  logic [12:0] pal[20];             // Palette image
  logic [12:0] cap[500];            // One raster of {flag, colour}
  // Each row: depth, word, sync width, slow source, frame sync cycles
  vpf_row_t rows[4] = '{'{BPP_1, 32'hA5C3_0F96, 10'h000, 1'b1, 11'h1F4},
                        '{BPP_2, 32'h1B6C_E4D2, 10'h001, 1'b0, 11'h3E8},
                        '{BPP_4, 32'h7654_3210, 10'h000, 1'b0, 11'h1F4},
                        '{BPP_8, 32'hC4F1_3A82, 10'h001, 1'b0, 11'h3E8}};

  always #5 clk = ~clk;

  vpf_timing #(.H_W(11), .V_W(10)) i_dut (
    .i_clk(clk), .i_sys_rst(rst), .i_bpp(bpp),
    .i_h_cycle(hc[0]), .i_h_sync_width(hc[1]), .i_h_border_start(hc[2]), .i_h_display_start(hc[3]),
    .i_h_display_end(hc[4]), .i_h_border_end(hc[5]), .i_h_cursor_start(hc[6]),
    .i_vert_cycle(vc[0]), .i_vert_sync_width_reg(vc[1]), .i_vert_border_start_reg(vc[2]),
    .i_vert_display_start_reg(vc[3]), .i_vert_display_end_reg(vc[4]), .i_vert_border_end_reg(vc[5]),
    .i_vert_cursor_start_reg(vc[6]), .i_vert_cursor_end_reg(vc[7]),
    .i_pal_wr(wr), .i_pal_addr(pa), .i_pal_data(pd),
    .i_video_word(vword), .i_video_valid(vvalid), .i_video_fifo_low(1'b1), .o_video_pop(vpop),
    .i_cursor_word(cword), .i_cursor_valid(1'b1), .o_cursor_pop(),
    .o_video_dma_request(vreq), .o_cursor_dma_request(creq), .o_line_sync_out_n(line_n),
    .o_frame_sync_n(frame_n), .o_flyback_flag(fly), .o_colour(col), .o_overlay_select_flag(overlay_select_flag));

  vpf_far_side u_far (
    .i_clk(clk), .i_sys_rst(rst), .i_vid_pat(vpat), .i_cur_pat(cpat), .i_slow(slow),
    .i_video_pop(vpop), .i_line_n(line_n), .i_frame_n(frame_n), .i_vreq(vreq), .i_creq(creq),
    .o_vid_word(vword), .o_vid_valid(vvalid), .o_cur_word(cword), .o_frame(far_frame),
    .o_raster(far_raster), .o_frame_low(far_frame_low), .o_vreq_cnt(far_vreq), .o_creq_cnt(far_creq));

  // Distinct palette entries so every colour on screen names its source
  function automatic logic [12:0] pv(input logic [3:0] i);
    return {i[0], i, 4'hF - i, i + 4'h1};
  endfunction

  // Expected colour word of display pixel k
  function automatic logic [12:0] ex(input logic [1:0] b, input logic [31:0] w, input int k);
    logic [7:0]  p;
    logic [12:0] c;
    p = 8'(w >> ((k << b) % 32)) & 8'((1 << (1 << b)) - 1);
    c = pv(p[3:0]);
    if (b == BPP_8) begin
      c[L7_POS] = p[7];
      c[L6_POS] = p[6];
      c[L5_POS] = p[5];
      c[L4_POS] = p[4];
    end
    return c;
  endfunction

  // Occurrences of one colour in the captured raster
  function automatic int cnt(input logic [12:0] v);
    int n = 0;
    foreach (cap[i]) if (cap[i] === v) n++;
    return n;
  endfunction

  task automatic check(input logic [31:0] seen, input logic [31:0] want, input string what);
    check_count++;
    if (seen !== want) begin
      n_mismatch++;
      $display("[ERR] %0t %s: got %h want %h", $time, what, seen, want);
    end
  endtask

  task automatic print_verdict();
    $display("Checks %0d, mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  // Geometry: sync 214 px, zero front porch, 128 display px
  task automatic base(input logic [9:0] s);
    @(posedge clk);
    hc <= '{11'h1F3, 11'h0D6, 11'h0F0, 11'h0F4, 11'h174, 11'h1F4, 11'h176};
    vc <= '{10'h007, s, 10'h002, 10'h003, 10'h007, 10'h008, 10'h004, 10'h000};
  endtask

  // Reset, idle levels, then a full palette load
  task automatic do_reset();
    rst <= 1'b1;
    repeat (8) @(posedge clk);
    #1 check({line_n, frame_n, fly, vreq, creq, overlay_select_flag, col}, {5'b11100, 13'h0000}, "reset levels");
    @(posedge clk);
    rst <= 1'b0;
    for (int i = 0; i < 20; i++) begin
      @(posedge clk);
      wr <= 1'b1;
      pa <= 5'(i);
      pd <= pal[i];
    end
    @(posedge clk);
    wr <= 1'b0;
  endtask

  task automatic wait_at(input int f, input int r);
    int t = 0;
    while (!(far_frame == f && far_raster == r) && t < 20000) begin
      @(posedge clk);
      #1 t++;
    end
    if (t >= 20000) check(0, 1, "raster wait");
  endtask

  task automatic grab(input int f, input int r);
    wait_at(f, r);
    for (int i = 0; i < 500; i++) begin
      @(posedge clk);
      #1 cap[i] = {overlay_select_flag, col};
    end
  endtask

  // Watchdog: tests need about 67000 cycles; a hang stops well inside the run budget
  initial begin
    repeat (90000) @(posedge clk);
    n_mismatch++;
    print_verdict();
  end

  initial begin
    int f;
    for (int i = 0; i < 16; i++) pal[i] = pv(4'(i));
    pal[16] = 13'h0ABC;
    pal[17] = 13'h0F0F;
    pal[18] = 13'h10F0;
    pal[19] = 13'h0FFF;
    // Ordinary cases: one depth per row, cursor hidden
    foreach (rows[n]) begin
      base(rows[n].vsw);
      bpp  <= rows[n].b;
      vpat <= rows[n].w;
      slow <= rows[n].s;
      do_reset();
      grab(2, 3);
      f = 0;
      while (f < 372 && (cap[f] === 13'h0000 || cap[f] === pal[16])) f++;
      for (int k = 0; k < 128; k++) check(cap[f + k], ex(rows[n].b, rows[n].w, k), "pixel");
      for (int r = 0; r < 8; r++) begin
        wait_at(3, r);
        repeat (250) @(posedge clk);
        #1 check(fly, (r < 3 || r > 6), "flyback");
      end
      check(far_frame_low, rows[n].fl, "frame sync width");
      check(far_vreq > 0, 1, "video requests");
      check(far_creq, 0, "cursor requests off");
    end
    // Cursor on, border ends at 380 so the cursor tail is cut
    base(10'h000);
    @(posedge clk);
    vc[7] <= 10'h006;
    hc[5] <= 11'h17C;
    do_reset();
    grab(2, 4);
    check(cnt(pal[17]), 1, "cursor colour 1");
    check(cnt(pal[18]), 1, "cursor colour 2");
    check(cnt(pal[19]), 3, "cursor clipped");
    check(cnt(pal[16]), 7, "transparent code");
    check(far_creq > 0, 1, "cursor requests on");
    // Border start above end: no border, no cursor, requests go on
    base(10'h000);
    @(posedge clk);
    vc[7] <= 10'h006;
    vc[2] <= 10'h009;
    do_reset();
    grab(2, 4);
    check(cnt(pal[17]) + cnt(pal[18]) + cnt(pal[19]), 0, "cursor hidden");
    check(cnt(pal[16]), 0, "border hidden");
    check(far_creq > 0, 1, "cursor requests kept");
    // Display end below start: border over the whole border window
    base(10'h000);
    @(posedge clk);
    vc[4] <= 10'h001;
    do_reset();
    grab(2, 4);
    check(cnt(pal[16]), 260, "screen off border");
    check(far_vreq, 0, "no video requests");
    print_verdict();
  end
endmodule
